/* File: verilog/ltsw_pkg.sv */
// Package for the low power amplifier loop switch and control register bank.
// Assumes an APB master with 32-bit data and byte addresses.
package ltsw_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned LTSW_ADDR_W = 16;
  localparam logic [LTSW_ADDR_W-1:0] LTSW_LOOP_SWITCH_CONFIG_OFS = 16'h20e4;
  localparam logic [LTSW_ADDR_W-1:0] LTSW_AMPLIFIER_CONTROL_OFS = 16'h20ec;
  localparam int unsigned LTSW_STORE_W = 16;
  localparam logic [LTSW_STORE_W-1:0] LTSW_LOOP_SWITCH_CONFIG_RST = 16'h0000;
  localparam logic [LTSW_STORE_W-1:0] LTSW_AMPLIFIER_CONTROL_RST = 16'h0003;

  // ==========================================================================
  // Field layout
  localparam int unsigned LTSW_RECALIBRATION_BIT = 15;
  localparam int unsigned LTSW_LOOP_SW_MSB = 13;
  localparam int unsigned LTSW_NUM_LOOP_SW = 14;
  localparam int unsigned LTSW_FILTER_LSB = 13;
  localparam int unsigned LTSW_FILTER_W = 3;
  localparam int unsigned LTSW_LOAD_LSB = 10;
  localparam int unsigned LTSW_LOAD_W = 3;
  localparam int unsigned LTSW_GAIN_LSB = 5;
  localparam int unsigned LTSW_GAIN_W = 5;

  // ==========================================================================
  // Register select, one-hot
  typedef enum logic [2:0] {
    LTSW_SEL_NONE = 3'b001,
    LTSW_SEL_SWITCH = 3'b010,
    LTSW_SEL_CONTROL = 3'b100
  } ltsw_sel_t;

  // ==========================================================================
  // Lines towards the analog loop
  typedef struct packed {
    logic recalibration_switch;
    logic [LTSW_NUM_LOOP_SW-1:0] loop_switch;
    logic filter_connect;
    logic [(1<<LTSW_FILTER_W)-2:0] filter_resistor_select;
    logic [(1<<LTSW_LOAD_W)-1:0] load_resistor_select;
    logic gain_connect;
    logic [(1<<LTSW_GAIN_W)-2:0] gain_resistor_select;
  } ltsw_analog_t;

endpackage : ltsw_pkg

/* File: verilog/ltsw_decode.sv */
// Registered one-hot decoder for one resistor selector field.
// Assumes the code is the next value of the field, so lines change with it.
`timescale 1ns/1ns
module ltsw_decode #(
  parameter int unsigned CODE_W = 3
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Code in
  input wire logic [CODE_W-1:0] code_in,
  // One line per code
  output logic [(1<<CODE_W)-1:0] sel_out
);

  logic [(1<<CODE_W)-1:0] sel_ff;
  logic [(1<<CODE_W)-1:0] nxt_sel;

  // ==========================================================================
  // Decode
  always_comb begin
    nxt_sel = '0;
    nxt_sel[code_in] = 1'b1;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sel_ff <= {{((1<<CODE_W)-1){1'b0}}, 1'b1};
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  assign sel_out = sel_ff;

endmodule : ltsw_decode

/* File: verilog/ltsw_regs.sv */
// Loop switch and amplifier control registers with APB slave and decoders.
// Assumes an APB master on clk_sys_in; outputs drive analog switch lines.
//
// How it works
// - Bit 15 closes recalibration switch when set.
// - Bits 13..0 drive numbered loop switches.
// - Switch register resets to zero.
// - Control register resets to three.
// - Filter selector in control bits 15..13.
// - Filter code zero disconnects filter path.
// - Codes 1..7 each select one resistor.
// - Registers at 0x20e4 and 0x20ec, read/write.
// - Filter code 7 selects the largest resistor.
// - Load selector in bits 12..10, eight codes.
// - Gain selector bits 9..5, zero disconnects.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module ltsw_regs
  import ltsw_pkg::*;
#(
  parameter int unsigned ADDR_W = LTSW_ADDR_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog loop lines
  output ltsw_analog_t analog_out
);

  // ==========================================================================
  // Address decode
  function automatic ltsw_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    if (addr == LTSW_LOOP_SWITCH_CONFIG_OFS) begin
      return LTSW_SEL_SWITCH;
    end else if (addr == LTSW_AMPLIFIER_CONTROL_OFS) begin
      return LTSW_SEL_CONTROL;
    end else begin
      return LTSW_SEL_NONE;
    end
  endfunction : decode_addr

  ltsw_sel_t sel;
  logic setup;
  logic access;
  logic wr;
  logic [LTSW_STORE_W-1:0] wmask;

  assign sel = decode_addr(paddr);
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // ==========================================================================
  // Storage
  logic [LTSW_STORE_W-1:0] sw_ff;
  logic [LTSW_STORE_W-1:0] nxt_sw;
  logic [LTSW_STORE_W-1:0] ctl_ff;
  logic [LTSW_STORE_W-1:0] nxt_ctl;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_sw = sw_ff;
    nxt_ctl = ctl_ff;
    if (wr && sel == LTSW_SEL_SWITCH) begin
      nxt_sw = (sw_ff & ~wmask) | (pwdata[LTSW_STORE_W-1:0] & wmask);
    end
    if (wr && sel == LTSW_SEL_CONTROL) begin
      nxt_ctl = (ctl_ff & ~wmask) | (pwdata[LTSW_STORE_W-1:0] & wmask);
    end
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (setup) begin
      unique case (sel)
        LTSW_SEL_SWITCH: begin
          nxt_rdata = {16'h0000, sw_ff};
        end
        LTSW_SEL_CONTROL: begin
          nxt_rdata = {16'h0000, ctl_ff};
        end
        LTSW_SEL_NONE: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sw_ff <= LTSW_LOOP_SWITCH_CONFIG_RST;
      ctl_ff <= LTSW_AMPLIFIER_CONTROL_RST;
      rdata_ff <= 32'h0000_0000;
    end else begin
      sw_ff <= nxt_sw;
      ctl_ff <= nxt_ctl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata = rdata_ff;
  assign pready = 1'b1;
  assign pslverr = access & (sel == LTSW_SEL_NONE);

  // ==========================================================================
  // Selector decoders
  logic [(1<<LTSW_FILTER_W)-1:0] filter_lines;
  logic [(1<<LTSW_LOAD_W)-1:0] load_lines;
  logic [(1<<LTSW_GAIN_W)-1:0] gain_lines;

  ltsw_decode #(.CODE_W(LTSW_FILTER_W)) u_filter_dec (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .code_in(nxt_ctl[LTSW_FILTER_LSB +: LTSW_FILTER_W]),
    .sel_out(filter_lines)
  );

  ltsw_decode #(.CODE_W(LTSW_LOAD_W)) u_load_dec (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .code_in(nxt_ctl[LTSW_LOAD_LSB +: LTSW_LOAD_W]),
    .sel_out(load_lines)
  );

  ltsw_decode #(.CODE_W(LTSW_GAIN_W)) u_gain_dec (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .code_in(nxt_ctl[LTSW_GAIN_LSB +: LTSW_GAIN_W]),
    .sel_out(gain_lines)
  );

  // ==========================================================================
  // Analog outputs
  always_comb begin
    analog_out.recalibration_switch = sw_ff[LTSW_RECALIBRATION_BIT];
    analog_out.loop_switch = sw_ff[LTSW_LOOP_SW_MSB:0];
    analog_out.filter_connect = ~filter_lines[0];
    analog_out.filter_resistor_select = filter_lines[(1<<LTSW_FILTER_W)-1:1];
    analog_out.load_resistor_select = load_lines;
    analog_out.gain_connect = ~gain_lines[0];
    analog_out.gain_resistor_select = gain_lines[(1<<LTSW_GAIN_W)-1:1];
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  logic [2:0] filter_code;
  assign filter_code = ctl_ff[LTSW_FILTER_LSB +: LTSW_FILTER_W];

  sequence s_sw_write;
    wr && sel == LTSW_SEL_SWITCH && pstrb[1] && pstrb[0];
  endsequence

  sequence s_ctl_write;
    wr && sel == LTSW_SEL_CONTROL && pstrb[1];
  endsequence

  sequence s_sw_read;
    setup && !pwrite && sel == LTSW_SEL_SWITCH;
  endsequence

  property p_recalibration_write;
    s_sw_write |=> analog_out.recalibration_switch == $past(pwdata[15]);
  endproperty
  a_recalibration_write: assert property (p_recalibration_write) else $error("recalibration line missed write");

  property p_loop_write;
    s_sw_write |=> analog_out.loop_switch == $past(pwdata[13:0]);
  endproperty
  a_loop_write: assert property (p_loop_write) else $error("loop switches missed write");

  property p_sw_reset;
    $fell(srst_in) |-> sw_ff == 16'h0000 && analog_out.loop_switch == 14'h0000;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("switch reg not zero after reset");

  property p_ctl_reset;
    $fell(srst_in) |-> ctl_ff == 16'h0003 && !analog_out.filter_connect;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("control reg not three after reset");

  property p_filter_write;
    s_ctl_write |=> filter_code == $past(pwdata[15:13]);
  endproperty
  a_filter_write: assert property (p_filter_write) else $error("filter field missed write");

  property p_filter_open;
    filter_code == 3'h0 |-> !analog_out.filter_connect && analog_out.filter_resistor_select == 7'h00;
  endproperty
  a_filter_open: assert property (p_filter_open) else $error("filter not disconnected");

  property p_filter_line;
    filter_code != 3'h0 |-> analog_out.filter_resistor_select == (7'h01 << (filter_code - 3'h1));
  endproperty
  a_filter_line: assert property (p_filter_line) else $error("wrong filter line");

  property p_filter_max;
    filter_code == 3'h7 |-> analog_out.filter_resistor_select[6];
  endproperty
  a_filter_max: assert property (p_filter_max) else $error("code 7 not on top line");

  property p_load_line;
    load_lines == (8'h01 << ctl_ff[12:10]);
  endproperty
  a_load_line: assert property (p_load_line) else $error("wrong load line");

  property p_gain_open;
    ctl_ff[9:5] == 5'h00 |-> !analog_out.gain_connect && $onehot0(analog_out.gain_resistor_select)
      && analog_out.gain_resistor_select == 31'h0;
  endproperty
  a_gain_open: assert property (p_gain_open) else $error("gain not disconnected");

  property p_read_sw;
    s_sw_read ##1 access |-> prdata == {16'h0000, $past(sw_ff)} && !pslverr;
  endproperty
  a_read_sw: assert property (p_read_sw) else $error("switch read wrong");

  property p_unmapped;
    access && sel == LTSW_SEL_NONE |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

endmodule : ltsw_regs

/* File: dv/ltsw_host.sv */
// APB master model standing in for host software.
// Assumes an APB slave clocked by clk_sys_in.
`timescale 1ns/1ns
module ltsw_host (
  // Clock
  input wire logic clk_sys_in,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // ==========================================================================
  // One transfer, held until pready; codes come from the bench
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    while (pready !== 1'b1) @(posedge clk_sys_in);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : ltsw_host

/* File: dv/ltsw_regs_test.sv */
// Self-checking bench for the loop switch register bank.
// Assumes ltsw_pkg and the host model are compiled first.
`timescale 1ns/1ns
module ltsw_regs_test
  import ltsw_pkg::*;
;
  localparam logic [15:0] SW = LTSW_LOOP_SWITCH_CONFIG_OFS;
  localparam logic [15:0] CT = LTSW_AMPLIFIER_CONTROL_OFS;
  logic clk_sys_in, srst_in, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] pstrb;
  ltsw_analog_t an;
  logic [15:0] m_sw, m_ct;
  int error_cnt, n_tests;

  ltsw_regs dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_out(an));
  ltsw_host host (.clk_sys_in(clk_sys_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic ltsw_analog_t exp_an(input logic [15:0] s, input logic [15:0] c);
    ltsw_analog_t a;
    a = '0;
    a.recalibration_switch = s[15];
    a.loop_switch = s[13:0];
    a.filter_connect = (c[15:13] != 3'h0);
    if (c[15:13] != 3'h0) a.filter_resistor_select[c[15:13] - 3'h1] = 1'b1;
    a.load_resistor_select[c[12:10]] = 1'b1;
    a.gain_connect = (c[9:5] != 5'h00);
    if (c[9:5] != 5'h00) a.gain_resistor_select[c[9:5] - 5'h01] = 1'b1;
    return a;
  endfunction : exp_an

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic e;
    host.xfer(w, a, d, s, r, e);
    check("pslverr", {63'h0, e}, {63'h0, (a !== SW && a !== CT)});
    if (!w) check("prdata", {32'h0, r}, {48'h0, (a == SW) ? m_sw : (a == CT) ? m_ct : 16'h0});
    if (w && a == SW && s[0]) m_sw[7:0] = d[7:0];
    if (w && a == SW && s[1]) m_sw[15:8] = d[15:8];
    if (w && a == CT && s[0]) m_ct[7:0] = d[7:0];
    if (w && a == CT && s[1]) m_ct[15:8] = d[15:8];
    @(negedge clk_sys_in);
    check("analog_out", {1'b0, an}, {1'b0, exp_an(m_sw, m_ct)});
    check("pready", {63'h0, pready}, 64'h1);
  endtask : acc

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  // ==========================================================================
  // Tests
  initial begin
    error_cnt = 0;
    n_tests = 0;
    rnd = 32'h43e193cd;
    srst_in = 1'b1;
    m_sw = 16'h0000;
    m_ct = 16'h0003;
    repeat (16) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    acc(1'b0, SW, 32'h0, 4'h0);
    acc(1'b0, CT, 32'h0, 4'h0);
    $display("Test reset values done");
    acc(1'b1, SW, 32'hffff_ffff, 4'hf);
    acc(1'b0, SW, 32'h0, 4'h0);
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      acc(1'b1, SW, rnd, rnd[19:16]);
      acc(1'b0, SW, 32'h0, 4'h0);
    end
    $display("Test switch register done");
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      acc(1'b1, CT, {rnd[31:16], i[2:0], i[2:0] + 3'h3, i[4:0], rnd[4:0]}, 4'hf);
      acc(1'b0, CT, 32'h0, 4'h0);
    end
    $display("Test selector codes done");
    acc(1'b1, 16'h20e8, rnd, 4'hf);
    acc(1'b0, 16'h20e8, 32'h0, 4'h0);
    acc(1'b1, 16'h20e0, ~rnd, 4'hf);
    acc(1'b0, CT, 32'h0, 4'h0);
    $display("Test unmapped done");
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    m_sw = 16'h0000;
    m_ct = 16'h0003;
    acc(1'b0, SW, 32'h0, 4'h0);
    acc(1'b0, CT, 32'h0, 4'h0);
    $display("Test second reset done");
    wrap_up();
  end
endmodule : ltsw_regs_test
